// ### design/btch_config_header.sv
`timescale 1ns/1ns

// ****************************************************************
// type one header bank: header kind through io high bound
// ****************************************************************
module btch_config_header (
  input  wire logic                   ref_clk_i,          // 10 MHz clock
  input  wire logic                   sys_rst_i,          // async reset, high
  input  wire btch_pkg::btch_cfg_req_t cfg_req_i,         // config request
  output btch_pkg::btch_cfg_rsp_t     cfg_rsp_o,          // completion
  input  wire logic                   ctrl_base_unlock_i, // diag bit 5 level
  input  wire logic [15:0]            io_low_upper_i,     // low bound 31:16
  input  wire logic [15:0]            io_high_upper_i,    // high bound 31:16
  input  wire logic                   cfg1_valid_i,       // type 1 strobe
  input  wire logic [7:0]             cfg1_bus_i,         // type 1 bus
  input  wire logic                   io_valid_i,         // io request strobe
  input  wire logic [31:0]            io_addr_i,          // io address
  output btch_pkg::btch_route_t       cfg1_route_o,       // routing decision
  output logic                        io_forward_o,       // forward io request
  output logic [31:0]                 ctrl_window_base_o, // control window
  output logic [7:0]                  upstream_bus_o,     // upstream number
  output logic [7:0]                  downstream_bus_o,   // downstream number
  output logic [7:0]                  highest_bus_o,      // highest number
  output logic [7:0]                  tenure_timer_o      // tenure timer
);

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [19:0] ctrl_base_addr;          // bits 31:12 of the window
  logic [7:0]  upstream_bus_number;
  logic [7:0]  downstream_bus_number;
  logic [7:0]  highest_downstream_bus;
  logic [7:0]  downstream_tenure_timer;
  logic [3:0]  io_low_bound_nibble;
  logic [3:0]  io_high_bound_nibble;

  logic [7:0]  header_layout_kind;
  logic [7:0]  self_test_control;
  logic [7:0]  io_window_low_bound;
  logic [7:0]  io_window_high_bound;
  logic [11:0] ctrl_low_bits;
  logic [31:0] io_low_full;
  logic [31:0] io_high_full;
  logic [31:0] next_rdata;

  btch_pkg::btch_cfg_rsp_t rsp;

  assign header_layout_kind = btch_pkg::HDR_KIND_VAL;

  assign self_test_control  = btch_pkg::SELF_TEST_VAL;

  // fixed low bits of the control base
  assign ctrl_low_bits = {btch_pkg::CTRL_RSVD_VAL,
                          btch_pkg::PREFETCH_VAL,
                          btch_pkg::MEM_TYPE_VAL,
                          btch_pkg::SPACE_KIND_FLAG_VAL};

  // width code in the low nibble
  assign io_window_low_bound  = {io_low_bound_nibble, btch_pkg::IO_ADDR_WIDTH_CODE};
  assign io_window_high_bound = {io_high_bound_nibble, btch_pkg::IO_ADDR_WIDTH_CODE};

  // upper half from the outside register
  assign io_low_full  = {io_low_upper_i, io_low_bound_nibble, btch_pkg::IO_LOW_FILL};

  assign io_high_full = {io_high_upper_i, io_high_bound_nibble, btch_pkg::IO_HIGH_FILL};

  // ****************************************************************
  // control window base
  // ****************************************************************

  // three lanes cover all 20 address bits
  // byte 1 only takes its top nibble, so bits 11:8 stay fixed at zero
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_base_addr <= btch_pkg::CTRL_BASE_RST;
    end else if (ctrl_base_unlock_i) begin
      if (btch_pkg::byte_hit(cfg_req_i, btch_pkg::OFS_CTRL_BASE + 8'h01)) begin
        ctrl_base_addr[3:0] <= cfg_req_i.wdata[15:12];
      end
      if (btch_pkg::byte_hit(cfg_req_i, btch_pkg::OFS_CTRL_BASE + 8'h02)) begin
        ctrl_base_addr[11:4] <= cfg_req_i.wdata[23:16];
      end
      if (btch_pkg::byte_hit(cfg_req_i, btch_pkg::OFS_CTRL_BASE + 8'h03)) begin
        ctrl_base_addr[19:12] <= cfg_req_i.wdata[31:24];
      end
    end
  end

  // ****************************************************************
  // bus numbers and tenure timer
  // ****************************************************************

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      upstream_bus_number <= btch_pkg::BUS_RST;
    end else if (btch_pkg::byte_hit(cfg_req_i, btch_pkg::OFS_UP_BUS)) begin
      upstream_bus_number <= btch_pkg::lane_data(cfg_req_i, btch_pkg::OFS_UP_BUS);
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      downstream_bus_number <= btch_pkg::BUS_RST;
    end else if (btch_pkg::byte_hit(cfg_req_i, btch_pkg::OFS_DOWN_BUS)) begin
      downstream_bus_number <= btch_pkg::lane_data(cfg_req_i, btch_pkg::OFS_DOWN_BUS);
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      highest_downstream_bus <= btch_pkg::BUS_RST;
    end else if (btch_pkg::byte_hit(cfg_req_i, btch_pkg::OFS_HIGH_BUS)) begin
      highest_downstream_bus <= btch_pkg::lane_data(cfg_req_i, btch_pkg::OFS_HIGH_BUS);
    end
  end

  // tenure timer value
  // only stored here; the downstream arbiter does the counting
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      downstream_tenure_timer <= btch_pkg::TENURE_RST;
    end else if (btch_pkg::byte_hit(cfg_req_i, btch_pkg::OFS_TENURE)) begin
      downstream_tenure_timer <= btch_pkg::lane_data(cfg_req_i, btch_pkg::OFS_TENURE);
    end
  end

  // ****************************************************************
  // io window nibbles
  // ****************************************************************

  // only the top nibble is kept
  // the width code nibble of the same byte is dropped on purpose
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      io_low_bound_nibble <= btch_pkg::IO_NIBBLE_RST;
    end else if (btch_pkg::byte_hit(cfg_req_i, btch_pkg::OFS_IO_LOW)) begin
      io_low_bound_nibble <= cfg_req_i.wdata[7:4];
    end
  end

  // only the top nibble is kept
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      io_high_bound_nibble <= btch_pkg::IO_NIBBLE_RST;
    end else if (btch_pkg::byte_hit(cfg_req_i, btch_pkg::OFS_IO_HIGH)) begin
      io_high_bound_nibble <= cfg_req_i.wdata[15:12];
    end
  end

  // ****************************************************************
  // read path and completion
  // ****************************************************************

  // read mux; bytes owned by neighbouring registers read zero here
  always_comb begin
    next_rdata = 32'h00000000;
    case (cfg_req_i.dword)
      btch_pkg::dword_of(btch_pkg::OFS_HDR_KIND): begin
        next_rdata = {self_test_control, header_layout_kind, 16'h0000};
      end
      btch_pkg::dword_of(btch_pkg::OFS_CTRL_BASE): begin
        next_rdata = {ctrl_base_addr, ctrl_low_bits};
      end
      btch_pkg::dword_of(btch_pkg::OFS_UP_BUS): begin
        next_rdata = {downstream_tenure_timer, highest_downstream_bus,
                      downstream_bus_number, upstream_bus_number};
      end
      btch_pkg::dword_of(btch_pkg::OFS_IO_LOW): begin
        next_rdata = {16'h0000, io_window_high_bound, io_window_low_bound};
      end
      default: begin
        next_rdata = 32'h00000000;
      end
    endcase
  end

  // every request completes one cycle later, writes with zero data
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rsp <= '0;
    end else begin
      rsp.valid <= cfg_req_i.valid;
      rsp.rdata <= (cfg_req_i.valid && !cfg_req_i.write) ? next_rdata : 32'h00000000;
    end
  end

  assign cfg_rsp_o          = rsp;
  assign ctrl_window_base_o = {ctrl_base_addr, ctrl_low_bits};
  assign upstream_bus_o     = upstream_bus_number;
  assign downstream_bus_o   = downstream_bus_number;
  assign highest_bus_o      = highest_downstream_bus;
  assign tenure_timer_o     = downstream_tenure_timer;

  // ****************************************************************
  // routing
  // ****************************************************************

  // routing uses the live bus numbers
  // io window bounds feed the forward decision
  btch_route_decode u_route (
    .ref_clk_i    (ref_clk_i),
    .sys_rst_i    (sys_rst_i),
    .down_bus_i   (downstream_bus_number),
    .high_bus_i   (highest_downstream_bus),
    .io_low_i     (io_low_full),
    .io_high_i    (io_high_full),
    .cfg1_valid_i (cfg1_valid_i),
    .cfg1_bus_i   (cfg1_bus_i),
    .io_valid_i   (io_valid_i),
    .io_addr_i    (io_addr_i),
    .route_o      (cfg1_route_o),
    .io_forward_o (io_forward_o)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  // bus bytes gathered in lane order so each lane check picks its own slice
  logic [31:0] bus_bytes;
  assign bus_bytes = {downstream_tenure_timer, highest_downstream_bus,
                      downstream_bus_number, upstream_bus_number};

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_rd(logic [5:0] dw);
    cfg_req_i.valid && !cfg_req_i.write && cfg_req_i.dword == dw;
  endsequence

  sequence s_bus_wr;
    cfg_req_i.valid && cfg_req_i.write && cfg_req_i.byte_en == 4'hf
      && cfg_req_i.dword == btch_pkg::dword_of(btch_pkg::OFS_UP_BUS);
  endsequence

  // a full write lands in every lane at its taking edge, whatever follows it
  property p_bus_lane(int lane);
    s_bus_wr |=> bus_bytes[8*lane +: 8] == $past(cfg_req_i.wdata[8*lane +: 8]);
  endproperty

  a_hdr_kind_read: assert property (
    s_rd(btch_pkg::dword_of(btch_pkg::OFS_HDR_KIND))
      |=> cfg_rsp_o.valid && cfg_rsp_o.rdata[23:16] == 8'h01)
    else $error("header kind byte not 01h");

  a_self_test_zero: assert property (
    s_rd(btch_pkg::dword_of(btch_pkg::OFS_SELF_TEST))
      |=> cfg_rsp_o.valid && cfg_rsp_o.rdata[31:24] == 8'h00)
    else $error("self test byte not zero");

  a_ctrl_base_lock: assert property (
    !ctrl_base_unlock_i |=> $stable(ctrl_base_addr))
    else $error("control base changed while locked");

  a_ctrl_base_write: assert property (
    (ctrl_base_unlock_i && cfg_req_i.valid && cfg_req_i.write && cfg_req_i.byte_en == 4'hf
      && cfg_req_i.dword == btch_pkg::dword_of(btch_pkg::OFS_CTRL_BASE))
      |=> ctrl_window_base_o == {$past(cfg_req_i.wdata[31:12]), 12'h000})
    else $error("control base did not take 20 address bits");

  a_ctrl_low_zero: assert property (
    s_rd(btch_pkg::dword_of(btch_pkg::OFS_CTRL_BASE)) |=> cfg_rsp_o.rdata[11:0] == 12'h000)
    else $error("control base low bits not zero");

  a_up_bus_rw: assert property (p_bus_lane(0))
    else $error("upstream bus number readback wrong");
  a_down_bus_rw: assert property (p_bus_lane(1))
    else $error("downstream bus number readback wrong");
  a_high_bus_rw: assert property (p_bus_lane(2))
    else $error("highest bus number readback wrong");
  a_tenure_rw: assert property (p_bus_lane(3))
    else $error("tenure timer readback wrong");

  a_io_low_bound: assert property (
    btch_pkg::byte_hit(cfg_req_i, btch_pkg::OFS_IO_LOW)
      |=> io_low_full[15:0] == {$past(cfg_req_i.wdata[7:4]), 12'h000})
    else $error("io low bound wrong");

  a_io_high_bound: assert property (
    btch_pkg::byte_hit(cfg_req_i, btch_pkg::OFS_IO_HIGH)
      |=> io_high_full[15:0] == {$past(cfg_req_i.wdata[15:12]), 12'hfff})
    else $error("io high bound wrong");

  a_io_width_code: assert property (
    s_rd(btch_pkg::dword_of(btch_pkg::OFS_IO_LOW))
      |=> cfg_rsp_o.rdata[3:0] == 4'h1 && cfg_rsp_o.rdata[11:8] == 4'h1)
    else $error("io width code not 1h");

  // the low bound itself must forward when the window is not empty
  a_io_upper_half: assert property (
    (io_valid_i
      && {io_low_upper_i, io_low_bound_nibble} <= {io_high_upper_i, io_high_bound_nibble}
      && io_addr_i == {io_low_upper_i, io_low_bound_nibble, btch_pkg::IO_LOW_FILL})
      |=> io_forward_o)
    else $error("io bound upper half not used by forward decision");

  a_ro_lane_keep: assert property (
    (cfg_req_i.valid && cfg_req_i.write && cfg_req_i.byte_en == 4'h1
      && cfg_req_i.dword == btch_pkg::dword_of(btch_pkg::OFS_CTRL_BASE))
      |=> $stable(ctrl_base_addr))
    else $error("read-only lane write disturbed control base");

endmodule // btch_config_header

// ### design/btch_pkg.sv
// ****************************************************************
// bridge header constants, carriers and helpers
// ****************************************************************
package btch_pkg;

  // byte offsets in configuration space
  localparam logic [7:0] OFS_HDR_KIND      = 8'h0e;
  localparam logic [7:0] OFS_SELF_TEST     = 8'h0f;
  localparam logic [7:0] OFS_CTRL_BASE     = 8'h10;
  localparam logic [7:0] OFS_UP_BUS        = 8'h18;
  localparam logic [7:0] OFS_DOWN_BUS      = 8'h19;
  localparam logic [7:0] OFS_HIGH_BUS      = 8'h1a;
  localparam logic [7:0] OFS_TENURE        = 8'h1b;
  localparam logic [7:0] OFS_IO_LOW        = 8'h1c;
  localparam logic [7:0] OFS_IO_HIGH       = 8'h1d;
  // upper io halves live outside this block
  localparam logic [7:0] OFS_IO_LOW_UPPER  = 8'h30;
  localparam logic [7:0] OFS_IO_HIGH_UPPER = 8'h32;

  // fixed read values and reset values
  localparam logic [7:0]  HDR_KIND_VAL        = 8'h01;
  localparam logic [7:0]  SELF_TEST_VAL       = 8'h00;
  localparam logic [19:0] CTRL_BASE_RST       = 20'h00000;
  localparam logic [7:0]  CTRL_RSVD_VAL       = 8'h00;
  localparam logic        PREFETCH_VAL        = 1'b0;
  localparam logic [1:0]  MEM_TYPE_VAL        = 2'h0;
  localparam logic        SPACE_KIND_FLAG_VAL = 1'b0;
  localparam logic [7:0]  BUS_RST             = 8'h00;
  localparam logic [7:0]  TENURE_RST          = 8'h00;
  localparam logic [3:0]  IO_NIBBLE_RST       = 4'h0;
  localparam logic [3:0]  IO_ADDR_WIDTH_CODE  = 4'h1;
  localparam logic [11:0] IO_LOW_FILL         = 12'h000;
  localparam logic [11:0] IO_HIGH_FILL        = 12'hfff;

  // field positions
  localparam int CTRL_ADDR_LSB = 12;
  localparam int IO_NIBBLE_LSB = 4;

  // one configuration request, one dword wide
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [5:0]  dword;
    logic [3:0]  byte_en;
    logic [31:0] wdata;
  } btch_cfg_req_t;

  // completion for every request, read data for reads
  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
  } btch_cfg_rsp_t;

  // type 1 configuration routing decision
  typedef enum logic [2:0] {
    ROUTE_NONE  = 3'b001,
    ROUTE_TYPE0 = 3'b010,
    ROUTE_TYPE1 = 3'b100
  } btch_route_t;

  function automatic logic [5:0] dword_of(input logic [7:0] ofs);
    return ofs[7:2];
  endfunction

  // write strobe for one byte of the header
  function automatic logic byte_hit(input btch_cfg_req_t req, input logic [7:0] ofs);
    return req.valid && req.write && (req.dword == ofs[7:2]) && req.byte_en[ofs[1:0]];
  endfunction

  function automatic logic [7:0] lane_data(input btch_cfg_req_t req, input logic [7:0] ofs);
    return req.wdata[{ofs[1:0], 3'b000} +: 8];
  endfunction

  // inclusive range check, both ends count
  function automatic logic in_range(input logic [31:0] v,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

endpackage

// ### design/btch_route_decode.sv
`timescale 1ns/1ns
// ****************************************************************
// routing decode for type 1 configuration and io forwarding
// ****************************************************************
module btch_route_decode (
  input  wire logic               ref_clk_i,      // 10 MHz clock
  input  wire logic               sys_rst_i,      // async reset, high
  input  wire logic [7:0]         down_bus_i,     // downstream bus number
  input  wire logic [7:0]         high_bus_i,     // highest downstream bus
  input  wire logic [31:0]        io_low_i,       // io window low bound
  input  wire logic [31:0]        io_high_i,      // io window high bound
  input  wire logic               cfg1_valid_i,   // type 1 request strobe
  input  wire logic [7:0]         cfg1_bus_i,     // its bus number
  input  wire logic               io_valid_i,     // io request strobe
  input  wire logic [31:0]        io_addr_i,      // its address
  output btch_pkg::btch_route_t   route_o,        // registered decision
  output logic                    io_forward_o    // registered forward flag
);

  logic [31:0] bus_w;
  logic [31:0] down_w;
  logic [31:0] high_w;

  assign bus_w  = {24'h000000, cfg1_bus_i};
  assign down_w = {24'h000000, down_bus_i};
  assign high_w = {24'h000000, high_bus_i};

  // secondary match first
  // equal bus wins so the bridge never forwards its own segment as type 1
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      route_o <= btch_pkg::ROUTE_NONE;
    end else if (!cfg1_valid_i) begin
      route_o <= btch_pkg::ROUTE_NONE;
    end else if (cfg1_bus_i == down_bus_i) begin
      route_o <= btch_pkg::ROUTE_TYPE0;
    end else if ((cfg1_bus_i > down_bus_i) && btch_pkg::in_range(bus_w, down_w, high_w)) begin
      route_o <= btch_pkg::ROUTE_TYPE1;
    end else begin
      route_o <= btch_pkg::ROUTE_NONE;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      io_forward_o <= 1'b0;
    end else begin
      io_forward_o <= io_valid_i && btch_pkg::in_range(io_addr_i, io_low_i, io_high_i);
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_io_forward_range: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    io_valid_i |=> (io_forward_o == ($past(io_addr_i) >= $past(io_low_i)
                                   && $past(io_addr_i) <= $past(io_high_i))))
    else $error("io forward flag disagrees with window");

  a_route_type0: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (cfg1_valid_i && cfg1_bus_i == down_bus_i) |=> route_o == btch_pkg::ROUTE_TYPE0)
    else $error("secondary bus not routed as type 0");

  a_route_type1: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (cfg1_valid_i && cfg1_bus_i > down_bus_i && cfg1_bus_i <= high_bus_i)
      |=> route_o == btch_pkg::ROUTE_TYPE1)
    else $error("subordinate range not routed as type 1");

endmodule // btch_route_decode

// ### bench/btch_host_model.sv
`timescale 1ns/1ns
// ****************************************************************
// host model: one configuration request at a time
// ****************************************************************
module btch_host_model (
  input  wire logic                    ref_clk_i, // bench clock
  input  wire btch_pkg::btch_cfg_rsp_t cfg_rsp_i, // completion in
  output btch_pkg::btch_cfg_req_t      cfg_req_o  // request out
);
  initial cfg_req_o = '0;

  // request stands up to its taking edge; the completion stands one
  // cycle only, so it is read straight after the edge that raised it
  task automatic access(input logic wr, input logic [5:0] dw, input logic [3:0] be,
                        input logic [31:0] wd, output logic [31:0] rd, output logic ok);
    @(posedge ref_clk_i);
    #1 cfg_req_o = '{1'b1, wr, dw, be, wd};
    @(posedge ref_clk_i);
    #1 cfg_req_o.valid = 1'b0;
    ok = cfg_rsp_i.valid;
    rd = cfg_rsp_i.rdata;
  endtask
endmodule // btch_host_model

// ### bench/btch_config_header_test.sv
`timescale 1ns/1ns
module btch_config_header_test;
  logic                    ref_clk_i = 1'b0;
  logic                    sys_rst_i = 1'b1;
  btch_pkg::btch_cfg_req_t cfg_req;
  btch_pkg::btch_cfg_rsp_t cfg_rsp;
  logic                    unlock    = 1'b0;
  logic [15:0]             lo_up     = 16'h0000;
  logic [15:0]             hi_up     = 16'h0000;
  logic                    c1_valid  = 1'b0;
  logic [7:0]              c1_bus    = 8'h00;
  logic                    io_valid  = 1'b0;
  logic [31:0]             io_addr   = 32'h0;
  btch_pkg::btch_route_t   route;
  logic                    io_fwd;
  logic [31:0]             win;
  logic [7:0]              up_bus, dn_bus, hi_bus, tenure;
  int                      errors    = 0;
  int                      checks    = 0;
  int                      cycles    = 0;

  always #50 ref_clk_i = ~ref_clk_i;

  btch_host_model btch_host_model_i (.ref_clk_i(ref_clk_i), .cfg_rsp_i(cfg_rsp),
                                     .cfg_req_o(cfg_req));
  btch_config_header btch_config_header_i (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .cfg_req_i(cfg_req), .cfg_rsp_o(cfg_rsp),
    .ctrl_base_unlock_i(unlock), .io_low_upper_i(lo_up), .io_high_upper_i(hi_up),
    .cfg1_valid_i(c1_valid), .cfg1_bus_i(c1_bus), .io_valid_i(io_valid), .io_addr_i(io_addr),
    .cfg1_route_o(route), .io_forward_o(io_fwd), .ctrl_window_base_o(win),
    .upstream_bus_o(up_bus), .downstream_bus_o(dn_bus), .highest_bus_o(hi_bus),
    .tenure_timer_o(tenure));

  task automatic wrap_up();
    if (errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // generous ceiling: the whole run needs well under 200 cycles
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // every read also checks that a completion came back
  task automatic rd(input logic [5:0] dw, input logic [31:0] e);
    logic [31:0] d;
    logic        ok;
    btch_host_model_i.access(1'b0, dw, 4'hf, 32'h0, d, ok);
    chk("completion", 32'h1, {31'h0, ok});
    chk($sformatf("dword %0d", dw), e, d);
  endtask

  task automatic wr(input logic [5:0] dw, input logic [3:0] be, input logic [31:0] wd);
    logic [31:0] d;
    logic        ok;
    btch_host_model_i.access(1'b1, dw, be, wd, d, ok);
    chk("write completion", 32'h1, {31'h0, ok});
  endtask

  task automatic route_probe(input logic [7:0] b, input btch_pkg::btch_route_t e);
    @(posedge ref_clk_i);
    #1 c1_valid = 1'b1;
    c1_bus = b;
    @(posedge ref_clk_i);
    #1 c1_valid = 1'b0;
    chk("route", e, route);
  endtask

  task automatic io_probe(input logic [31:0] a, input logic e);
    @(posedge ref_clk_i);
    #1 io_valid = 1'b1;
    io_addr = a;
    @(posedge ref_clk_i);
    #1 io_valid = 1'b0;
    chk("io forward", {31'h0, e}, {31'h0, io_fwd});
  endtask

  task automatic t_reset();
    rd(6'd3, 32'h0001_0000);
    rd(6'd4, 32'h0);
    rd(6'd6, 32'h0);
    rd(6'd7, 32'h0000_0101);
  endtask

  // writes into fixed bytes and a locked base, then a read of an unmapped dword
  task automatic t_readonly();
    wr(6'd3, 4'hf, 32'hffff_ffff);
    wr(6'd4, 4'hf, 32'hffff_ffff);
    rd(6'd3, 32'h0001_0000);
    rd(6'd4, 32'h0);
    rd(6'd8, 32'h0);
  endtask

  task automatic t_unlock();
    unlock = 1'b1;
    wr(6'd4, 4'hf, 32'hffff_ffff);
    rd(6'd4, 32'hffff_f000);
    wr(6'd4, 4'h2, 32'h0000_5a00);
    rd(6'd4, 32'hffff_5000);
    wr(6'd4, 4'h1, 32'hffff_ffff);
    rd(6'd4, 32'hffff_5000);
    unlock = 1'b0;
    wr(6'd4, 4'hf, 32'h0);
    rd(6'd4, 32'hffff_5000);
    chk("window base", 32'hffff_5000, win);
  endtask

  // full then partial byte-lane write of the four bus bytes
  task automatic t_bus();
    wr(6'd6, 4'hf, 32'h4433_2211);
    wr(6'd6, 4'h5, 32'haabb_ccdd);
    rd(6'd6, 32'h44bb_22dd);
    chk("buses", 32'h44bb_22dd, {tenure, hi_bus, dn_bus, up_bus});
  endtask

  // window 0012_3000 .. 0034_5fff, probed on both sides of each bound
  task automatic t_io();
    wr(6'd7, 4'hf, 32'hffff_5a3f);
    rd(6'd7, 32'h0000_5131);
    lo_up = 16'h0012;
    hi_up = 16'h0034;
    io_probe(32'h0012_3000, 1'b1);
    io_probe(32'h0012_2fff, 1'b0);
    io_probe(32'h0034_5fff, 1'b1);
    io_probe(32'h0034_6000, 1'b0);
  endtask

  // downstream 22h, highest bbh from t_bus
  task automatic t_route();
    route_probe(8'h22, btch_pkg::ROUTE_TYPE0);
    route_probe(8'h23, btch_pkg::ROUTE_TYPE1);
    route_probe(8'hbb, btch_pkg::ROUTE_TYPE1);
    route_probe(8'hbc, btch_pkg::ROUTE_NONE);
    route_probe(8'h21, btch_pkg::ROUTE_NONE);
  endtask

  // a reset in mid-run must clear every field written so far
  task automatic t_rerst();
    @(posedge ref_clk_i);
    #1 sys_rst_i = 1'b1;
    @(posedge ref_clk_i);
    #1 sys_rst_i = 1'b0;
    t_reset();
    chk("window base", 32'h0, win);
    chk("buses", 32'h0, {tenure, hi_bus, dn_bus, up_bus});
  endtask

  initial begin
    repeat (4) @(posedge ref_clk_i);
    #1 sys_rst_i = 1'b0;
    t_reset();
    t_readonly();
    t_unlock();
    t_bus();
    t_io();
    t_route();
    t_rerst();
    wrap_up();
  end
endmodule // btch_config_header_test
